// *** design/nvsc_host.sv ***
/*
 * host controller for a 32K x 8 nvSRAM: plain reads and writes plus
 * software store/recall by the six-read sequence, and power-up wait.
 * assumes a one-clock user side and device pins that are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module nvsc_host
    import nvsc_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  req_valid_i,
    input  wire nvsc_pkg::nvsc_op_t    req_op_i,
    input  wire logic [nvsc_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [nvsc_pkg::DATA_W-1:0] req_wdata_i,
    input  wire logic                  req_use_oe_i,
    output logic                       req_ready_o,
    output logic                       rsp_valid_o,
    output logic [nvsc_pkg::DATA_W-1:0] rsp_rdata_o,
    output logic                       nv_busy_o,
    output logic                       ce_n_o,
    output logic                       we_n_o,
    output logic                       oe_n_o,
    output logic [nvsc_pkg::ADDR_W-1:0] address_bus_o,
    output logic [nvsc_pkg::DATA_W-1:0] data_bus_o,
    output logic                       data_bus_oe_o,
    input  wire logic [nvsc_pkg::DATA_W-1:0] data_bus_i
);
    import nvsc_pkg::*;

    typedef enum logic [2:0] {
        NVSC_PWRUP,
        NVSC_IDLE,
        NVSC_ACCESS,
        NVSC_SEQ,
        NVSC_NVWAIT
    } nvsc_state_t;

    nvsc_state_t       st_reg;
    nvsc_op_t          op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic              oe_reg;
    logic [2:0]        step_reg;
    logic              issued_reg;
    logic [WAIT_W-1:0] wait_reg;
    logic [DATA_W-1:0] dsync1_reg;
    logic [DATA_W-1:0] dsync2_reg;
    logic [ADDR_W-1:0] seq_addr;

    nvsc_cyc_if cyc ();

    // read data comes off the pins, so two flops before the engine samples it
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            dsync1_reg <= '0;
            dsync2_reg <= '0;
        end else begin
            dsync1_reg <= data_bus_i;
            dsync2_reg <= dsync1_reg;
        end
    end

    // the whole sequence is reads at a fixed order; msb kept zero as device ignores it
    always_comb begin
        case (step_reg)
            3'd0:    seq_addr = SEQ_A1;
            3'd1:    seq_addr = SEQ_A2;
            3'd2:    seq_addr = SEQ_A3;
            3'd3:    seq_addr = SEQ_A4;
            3'd4:    seq_addr = SEQ_A5;
            default: seq_addr = (op_reg == NVSC_OP_STORE) ? SEQ_STORE : SEQ_RECALL;
        endcase
    end

    always_comb begin
        cyc.start    = 1'b0;
        cyc.is_write = 1'b0;
        cyc.use_oe   = oe_reg;
        cyc.addr     = addr_reg;
        cyc.wdata    = wdata_reg;
        if (st_reg == NVSC_ACCESS && !issued_reg) begin
            cyc.start    = 1'b1;
            cyc.is_write = (op_reg == NVSC_OP_WRITE);
        end else if (st_reg == NVSC_SEQ && !issued_reg) begin
            cyc.start    = 1'b1;
            cyc.is_write = 1'b0; // write enable held high
            cyc.addr     = seq_addr;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_reg      <= NVSC_PWRUP;
            op_reg      <= NVSC_OP_READ;
            addr_reg    <= '0;
            wdata_reg   <= '0;
            oe_reg      <= 1'b1;
            step_reg    <= 3'd0;
            issued_reg  <= 1'b0;
            // wait out the device's power-up recall before any access
            wait_reg    <= WAIT_W'(PWRUP_CYC);
            req_ready_o <= 1'b0;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= '0;
            nv_busy_o   <= 1'b1;
        end else begin
            rsp_valid_o <= 1'b0;
            case (st_reg)
                NVSC_PWRUP: begin
                    if (wait_reg == '0) begin
                        nv_busy_o   <= 1'b0;
                        req_ready_o <= 1'b1;
                        st_reg      <= NVSC_IDLE;
                    end else begin
                        wait_reg <= wait_reg - WAIT_W'(1);
                    end
                end
                NVSC_IDLE: begin
                    if (req_valid_i) begin
                        req_ready_o <= 1'b0;
                        op_reg      <= req_op_i;
                        addr_reg    <= req_addr_i;
                        wdata_reg   <= req_wdata_i;
                        oe_reg      <= req_use_oe_i; // irrelevant to nv start
                        issued_reg  <= 1'b0;
                        step_reg    <= 3'd0;
                        if (req_op_i == NVSC_OP_STORE || req_op_i == NVSC_OP_RECALL) begin
                            nv_busy_o <= 1'b1;
                            st_reg    <= NVSC_SEQ;
                        end else begin
                            st_reg <= NVSC_ACCESS;
                        end
                    end
                end
                NVSC_ACCESS: begin
                    // the engine's busy flag marks the access as taken, so it is issued once
                    issued_reg <= issued_reg | cyc.busy;
                    if (cyc.done) begin
                        rsp_rdata_o <= cyc.rdata;
                        rsp_valid_o <= 1'b1;
                        req_ready_o <= 1'b1;
                        st_reg      <= NVSC_IDLE;
                    end
                end
                NVSC_SEQ: begin
                    // no other access is interleaved, so the sequence is never aborted
                    issued_reg <= issued_reg | cyc.busy;
                    if (cyc.done) begin
                        issued_reg <= 1'b0;
                        if (step_reg == 3'(SEQ_LEN - 1)) begin
                            // device ignores pins until done; wait full max time
                            wait_reg <= (op_reg == NVSC_OP_STORE) ? WAIT_W'(STORE_CYC)
                                                                  : WAIT_W'(RECALL_CYC);
                            st_reg   <= NVSC_NVWAIT;
                        end else begin
                            // first five reads return data but it is discarded
                            step_reg <= step_reg + 3'd1;
                        end
                    end
                end
                NVSC_NVWAIT: begin
                    if (wait_reg == '0) begin
                        rsp_valid_o <= 1'b1;
                        nv_busy_o   <= 1'b0;
                        req_ready_o <= 1'b1;
                        st_reg      <= NVSC_IDLE;
                    end else begin
                        wait_reg <= wait_reg - WAIT_W'(1);
                    end
                end
                default: st_reg <= NVSC_IDLE;
            endcase
        end
    end

    nvsc_cycle_engine u_engine (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .cyc         (cyc),
        .data_sync_i (dsync2_reg),
        .ce_n_o      (ce_n_o),
        .we_n_o      (we_n_o),
        .oe_n_o      (oe_n_o),
        .addr_o      (address_bus_o),
        .data_out_o  (data_bus_o),
        .data_oe_o   (data_bus_oe_o)
    );
endmodule // nvsc_host
`default_nettype wire

// *** design/nvsc_pkg.sv ***
/*
 * package for the host-side controller of a 32K x 8 nvSRAM with store/recall.
 * assumes a 125 MHz system clock (8 ns period) and the device's asynchronous pins.
 */
package nvsc_pkg;
    localparam int unsigned CLK_PERIOD_PS     = 8000;
    localparam int unsigned ADDR_W            = 15;
    localparam int unsigned DATA_W            = 8;
    // access phase timings in ns, with cycle counts rounded up
    localparam int unsigned T_SETUP_NS        = 8;
    localparam int unsigned T_PULSE_NS        = 56;
    localparam int unsigned T_RECOVER_NS      = 16;
    localparam int unsigned SETUP_CYC  = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned PULSE_CYC  = (T_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RECOV_CYC  = (T_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // nonvolatile wait times
    localparam int unsigned T_STORE_MS        = 10;
    localparam int unsigned T_RECALL_US       = 20;
    localparam int unsigned T_PWRUP_RECALL_US = 650;
    localparam int unsigned T_RELEASE_NS      = 600;
    localparam int unsigned STORE_CYC   = (T_STORE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
    localparam int unsigned RECALL_CYC  = (T_RECALL_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int unsigned PWRUP_CYC   = (T_PWRUP_RECALL_US * 1000) / (CLK_PERIOD_PS / 1000);
    localparam int unsigned RELEASE_CYC = (T_RELEASE_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned WAIT_W      = 24;
    // sequence addresses
    localparam logic [ADDR_W-1:0] SEQ_A1    = 15'h0e38;
    localparam logic [ADDR_W-1:0] SEQ_A2    = 15'h31c7;
    localparam logic [ADDR_W-1:0] SEQ_A3    = 15'h03e0;
    localparam logic [ADDR_W-1:0] SEQ_A4    = 15'h3c1f;
    localparam logic [ADDR_W-1:0] SEQ_A5    = 15'h303f;
    localparam logic [ADDR_W-1:0] SEQ_STORE = 15'h0fc0;
    localparam logic [ADDR_W-1:0] SEQ_RECALL= 15'h0c63;
    localparam logic [ADDR_W-1:0] SEQ_TEST  = 15'h339c;
    localparam int unsigned SEQ_LEN = 6;

    typedef enum logic [1:0] {
        NVSC_OP_READ,
        NVSC_OP_WRITE,
        NVSC_OP_STORE,
        NVSC_OP_RECALL
    } nvsc_op_t;
endpackage

// *** design/nvsc_cyc_if.sv ***
/*
 * carrier between the controller top and its pin-cycle engine.
 * assumes one clock; all signals are synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
interface nvsc_cyc_if;
    import nvsc_pkg::*;
    logic              start;
    logic              is_write;
    logic              use_oe;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport master (output start, is_write, use_oe, addr, wdata, input busy, done, rdata);
    modport engine (input start, is_write, use_oe, addr, wdata, output busy, done, rdata);
endinterface
`default_nettype wire

// *** design/nvsc_cycle_engine.sv ***
/*
 * pin cycle engine: runs one chip-enable controlled access on the device pins.
 * assumes the device data bus is returned already synchronised by the top.
 */
`timescale 1ns/1ps
`default_nettype none
module nvsc_cycle_engine
    import nvsc_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    nvsc_cyc_if.engine             cyc,
    input  wire logic [DATA_W-1:0] data_sync_i,
    output logic                   ce_n_o,
    output logic                   we_n_o,
    output logic                   oe_n_o,
    output logic [ADDR_W-1:0]      addr_o,
    output logic [DATA_W-1:0]      data_out_o,
    output logic                   data_oe_o
);
    typedef enum logic [1:0] {
        NVSC_CE_IDLE,
        NVSC_CE_SETUP,
        NVSC_CE_PULSE,
        NVSC_CE_RECOV
    } nvsc_ce_t;

    nvsc_ce_t   st_reg;
    logic [3:0] cnt_reg;
    logic       wr_reg;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_reg     <= NVSC_CE_IDLE;
            cnt_reg    <= 4'h0;
            wr_reg     <= 1'b0;
            ce_n_o     <= 1'b1;
            we_n_o     <= 1'b1;
            oe_n_o     <= 1'b1;
            addr_o     <= '0;
            data_out_o <= '0;
            data_oe_o  <= 1'b0;
            cyc.done   <= 1'b0;
            cyc.rdata  <= '0;
        end else begin
            cyc.done <= 1'b0;
            case (st_reg)
                NVSC_CE_IDLE: begin
                    if (cyc.start) begin
                        addr_o     <= cyc.addr;
                        data_out_o <= cyc.wdata;
                        wr_reg     <= cyc.is_write;
                        data_oe_o  <= cyc.is_write;
                        // write enable drops before chip enable so outputs stay off
                        we_n_o     <= ~cyc.is_write;
                        cnt_reg    <= 4'(SETUP_CYC);
                        st_reg     <= NVSC_CE_SETUP;
                    end
                end
                NVSC_CE_SETUP: begin
                    if (cnt_reg <= 4'h1) begin
                        ce_n_o  <= 1'b0; // one low pulse per access
                        oe_n_o  <= wr_reg | ~cyc.use_oe;
                        cnt_reg <= 4'(PULSE_CYC);
                        st_reg  <= NVSC_CE_PULSE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                NVSC_CE_PULSE: begin
                    if (cnt_reg <= 4'h1) begin
                        // pulse exceeds access time, so read data is valid here
                        cyc.rdata <= data_sync_i;
                        ce_n_o    <= 1'b1;
                        oe_n_o    <= 1'b1;
                        cnt_reg   <= 4'(RECOV_CYC);
                        st_reg    <= NVSC_CE_RECOV;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                NVSC_CE_RECOV: begin
                    we_n_o    <= 1'b1;
                    data_oe_o <= 1'b0;
                    if (cnt_reg <= 4'h1) begin
                        cyc.done <= 1'b1;
                        st_reg   <= NVSC_CE_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                default: st_reg <= NVSC_CE_IDLE;
            endcase
        end
    end

    assign cyc.busy = (st_reg != NVSC_CE_IDLE) | cyc.start;
endmodule // nvsc_cycle_engine
`default_nettype wire

// *** tb/nvsc_host_chk.sv ***
/*
 * checker for the host pins: initiation order, write enable and chip-enable pulses.
 * assumes it is bound to nvsc_host and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_chk
    import nvsc_pkg::*;
(
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire logic              nv_busy_o,
    input wire logic              ce_n_o,
    input wire logic              we_n_o,
    input wire logic [ADDR_W-1:0] address_bus_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    localparam logic [13:0] SEQ_TAB [5] = '{SEQ_A1[13:0], SEQ_A2[13:0], SEQ_A3[13:0],
                                           SEQ_A4[13:0], SEQ_A5[13:0]};
    logic        ce_q_reg;
    logic [2:0]  step_reg;
    logic        ce_fall;
    logic [13:0] a14;
    assign ce_fall = ce_q_reg & ~ce_n_o;
    // the device ignores the top address bit, so the sequence checks judge only the low 14
    assign a14 = address_bus_o[13:0];
    always_ff @(posedge clk_sys_i) begin
        ce_q_reg <= !rst_n_i ? 1'b1 : ce_n_o;
    end
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || !nv_busy_o) begin
            step_reg <= 3'h0;
        end else if (ce_fall) begin
            step_reg <= step_reg + 3'h1;
        end
    end
    a_seq_order: assert property (nv_busy_o && ce_fall && step_reg < 3'h5
        |-> a14 == SEQ_TAB[step_reg]) else $error("sequence address out of order");
    a_seq_final: assert property (nv_busy_o && ce_fall && step_reg == 3'h5
        |-> a14 == SEQ_STORE[13:0] || a14 == SEQ_RECALL[13:0])
        else $error("sixth sequence address wrong");
    a_seq_count: assert property (nv_busy_o && ce_fall |-> step_reg < 3'h6)
        else $error("more than six accesses in a sequence");
    a_seq_no_test: assert property (nv_busy_o && !ce_n_o |-> a14 != SEQ_TEST[13:0])
        else $error("reserved test address issued");
    a_seq_we_high: assert property (nv_busy_o |-> we_n_o)
        else $error("write enable low during sequence");
    a_ce_addr_stable: assert property (!ce_n_o && $past(!ce_n_o) |-> $stable(address_bus_o))
        else $error("address moved while selected");
    a_ce_pulse_bounded: assert property (ce_fall |-> (!ce_n_o)[*5] ##[1:6] ce_n_o)
        else $error("chip enable pulse width wrong");
endmodule // nvsc_host_chk
bind nvsc_host nvsc_host_chk i_nvsc_host_chk (
    .clk_sys_i     (clk_sys_i),
    .rst_n_i       (rst_n_i),
    .nv_busy_o     (nv_busy_o),
    .ce_n_o        (ce_n_o),
    .we_n_o        (we_n_o),
    .address_bus_o (address_bus_o)
);
`default_nettype wire

// *** tb/nvsc_dev_model.sv ***
/*
 * behavioural model of the nvSRAM behind the host pins.
 * assumes the bench resolves the shared data wire from both enables.
 */
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev_model #(
    parameter int NV_NS     = 1000,
    parameter int RECALL_NS = 20000
) (
    input  wire logic        pwr_ok_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [14:0] addr_i,
    input  wire logic [7:0]  data_i,
    output logic [7:0]       data_o,
    output logic             data_oe_o,
    output int               store_cnt_o,
    output int               recall_cnt_o
);
    localparam logic [13:0] SEQ [5] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
    logic [7:0] mem [32768];
    logic [7:0] shadow [32768];
    logic       nv_act = 1'b0;
    logic       wr_pend = 1'b0;
    logic       dirty = 1'b0;
    logic       is_store;
    int         step = 0;
    initial begin
        store_cnt_o = 0;
        recall_cnt_o = 0;
        foreach (shadow[i]) shadow[i] = 8'ha5;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    assign data_oe_o = !ce_n_i && !oe_n_i && we_n_i && !wr_pend && !nv_act;
    assign data_o    = mem[addr_i];
    // blocking in the delay keeps every pin ignored until the cycle is over
    always @(negedge ce_n_i) begin
        wr_pend = !we_n_i;
        if (!we_n_i) begin
            step = 0;
        end else if (step == 5) begin
            is_store = addr_i[13:0] == 14'h0fc0;
            if (is_store || addr_i[13:0] == 14'h0c63) begin
                nv_act = 1'b1;
                // store is cut short as its full time is beyond the run; recall takes its longest
                #(is_store ? NV_NS : RECALL_NS);
                if (is_store) foreach (mem[i]) shadow[i] = mem[i];
                else foreach (mem[i]) mem[i] = shadow[i];
                if (is_store) store_cnt_o++;
                else recall_cnt_o++;
                dirty = 1'b0;
                nv_act = 1'b0;
            end
            step = 0;
        end else if (addr_i[13:0] == SEQ[step]) begin
            step++;
        end else begin
            step = (addr_i[13:0] == SEQ[0]) ? 1 : 0;
        end
    end
    always @(posedge ce_n_i) begin
        if (wr_pend) begin
            mem[addr_i] = data_i;
            dirty = 1'b1;
            wr_pend = 1'b0;
        end
    end
    // supply loss: a running access gets its time, then only written data is stored
    always @(negedge pwr_ok_i) begin
        #(1000);
        if (dirty) begin
            foreach (mem[i]) shadow[i] = mem[i];
            store_cnt_o++;
            dirty = 1'b0;
        end
    end
    // supply back: the array is refilled from the shadow copy
    always @(posedge pwr_ok_i) begin
        foreach (mem[i]) mem[i] = shadow[i];
        recall_cnt_o++;
        dirty = 1'b0;
    end
endmodule // nvsc_dev_model
`default_nettype wire

// *** tb/nvsc_host_tb.sv ***
/*
 * testbench for nvsc_host: reset wait, reads and writes, software recall and store.
 * assumes the package timings and the device model on the pins.
 */
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_tb
    import nvsc_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              pwr_ok = 1'b0;
    logic              req_valid = 1'b0;
    nvsc_op_t          req_op = NVSC_OP_READ;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic              req_use_oe = 1'b1;
    logic              req_ready, rsp_valid, nv_busy, ce_n, we_n, oe_n, hb_oe, dev_oe;
    logic [DATA_W-1:0] rsp_rdata, hb_d, dev_d, dbus, held;
    logic [ADDR_W-1:0] abus;
    int                store_cnt, recall_cnt;
    int                err_count = 0;
    int                n_checks = 0;
    always #4 clk = ~clk;
    nvsc_host i_nvsc_host (.clk_sys_i(clk), .rst_n_i(rst_n), .req_valid_i(req_valid),
        .req_op_i(req_op), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
        .req_use_oe_i(req_use_oe), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
        .rsp_rdata_o(rsp_rdata), .nv_busy_o(nv_busy), .ce_n_o(ce_n), .we_n_o(we_n),
        .oe_n_o(oe_n), .address_bus_o(abus), .data_bus_o(hb_d), .data_bus_oe_o(hb_oe),
        .data_bus_i(dbus));
    nvsc_dev_model i_nvsc_dev_model (.pwr_ok_i(pwr_ok), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .addr_i(abus), .data_i(dbus), .data_o(dev_d), .data_oe_o(dev_oe),
        .store_cnt_o(store_cnt), .recall_cnt_o(recall_cnt));
    // an undriven wire shows the inverse of its last value, never a friendly copy
    always @* dbus = hb_oe ? hb_d : (dev_oe ? dev_d : ~held);
    always @(posedge clk) if (hb_oe || dev_oe) held <= dbus;
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic xfer(nvsc_op_t op, logic [14:0] a, logic [7:0] d, logic oe, int lim,
                        output logic got, output logic [7:0] q);
        int n;
        @(negedge clk);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_wdata = d;
        req_use_oe = oe;
        while (req_ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        got = rsp_valid === 1'b1;
        q = rsp_rdata;
    endtask
    task automatic t_reset;
        int n;
        repeat (4) @(negedge clk);
        pwr_ok = 1'b1;
        chk("reset ce_n", 32'(ce_n), 32'h1);
        chk("reset ready", 32'(req_ready), 32'h0);
        chk("reset busy", 32'(nv_busy), 32'h1);
        rst_n = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < PWRUP_CYC + 100) begin
            @(negedge clk);
            n++;
        end
        chk("powerup ready", 32'(req_ready), 32'h1);
        chk("powerup wait", 32'(n >= PWRUP_CYC), 32'h1);
        chk("powerup busy", 32'(nv_busy), 32'h0);
        chk("powerup recall", 32'(recall_cnt), 32'h1);
        $display("test reset done");
    endtask
    task automatic t_power;
        // supply dips while idle: written data is kept once, a clean dip stores nothing
        @(negedge clk);
        pwr_ok = 1'b0;
        repeat (250) @(negedge clk);
        chk("powerdown store", 32'(store_cnt), 32'h1);
        chk("powerdown data", 32'(i_nvsc_dev_model.shadow[15'h0100]), 32'h5a);
        pwr_ok = 1'b1;
        @(negedge clk);
        chk("powerup recall", 32'(recall_cnt), 32'h2);
        pwr_ok = 1'b0;
        repeat (250) @(negedge clk);
        chk("clean powerdown", 32'(store_cnt), 32'h1);
        pwr_ok = 1'b1;
        @(negedge clk);
        chk("powerup recall", 32'(recall_cnt), 32'h3);
        $display("test power done");
    endtask
    task automatic t_rw;
        logic [14:0] tab [4] = '{15'h0100, 15'h4e38, 15'h7fff, 15'h0000};
        logic        g;
        logic [7:0]  q;
        foreach (tab[i]) xfer(NVSC_OP_WRITE, tab[i], tab[i][7:0] ^ 8'h5a, 1'b1, 40, g, q);
        foreach (tab[i]) begin
            xfer(NVSC_OP_READ, tab[i], 8'h00, 1'b1, 40, g, q);
            chk("read done", 32'(g), 32'h1);
            chk("read data", 32'(q), 32'(tab[i][7:0] ^ 8'h5a));
        end
        $display("test read write done");
    endtask
    task automatic t_recall;
        logic       g;
        logic [7:0] q;
        xfer(NVSC_OP_WRITE, 15'h0100, 8'h3c, 1'b1, 40, g, q);
        // output enable left high: the sequence must still be taken
        xfer(NVSC_OP_RECALL, 15'h0000, 8'h00, 1'b0, RECALL_CYC + 300, g, q);
        chk("recall done", 32'(g), 32'h1);
        chk("recall count", 32'(recall_cnt), 32'h4);
        chk("store count", 32'(store_cnt), 32'h1);
        xfer(NVSC_OP_READ, 15'h0100, 8'h00, 1'b1, 40, g, q);
        chk("recalled data", 32'(q), 32'h5a);
        $display("test recall done");
    endtask
    task automatic t_store;
        logic       g;
        logic [7:0] q;
        xfer(NVSC_OP_WRITE, 15'h0200, 8'h77, 1'b1, 40, g, q);
        // the full store wait is far beyond this run, so the host is judged still busy and the model's shortened store done
        xfer(NVSC_OP_STORE, 15'h0000, 8'h00, 1'b1, 300, g, q);
        chk("store early response", 32'(g), 32'h0);
        chk("store count", 32'(store_cnt), 32'h2);
        chk("store busy", 32'(nv_busy), 32'h1);
        chk("stored data", 32'(i_nvsc_dev_model.shadow[15'h0200]), 32'h77);
        $display("test store done");
    endtask
    initial begin
        repeat (PWRUP_CYC + RECALL_CYC + 11000) @(posedge clk);
        err_count++;
        $display("watchdog expired");
        wrap_up();
    end
    initial begin
        t_reset();
        t_rw();
        t_power();
        t_recall();
        t_store();
        wrap_up();
    end
endmodule // nvsc_host_tb
`default_nettype wire
